//--- hw/sbc_defs.svh
`ifndef SBC_DEFS_SVH
`define SBC_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SBC_ADDR_STATUS  16'hFFA3
`define SBC_ADDR_SELECT  16'hFFA4
`define SBC_ADDR_MOC     16'hFFA2
`define SBC_ADDR_PCC     16'hFFFB
`define SBC_ADDR_RCM     16'hFFA0
`define SBC_ADDR_MCM     16'hFFA1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SBC_BIT_MAIN_OFF   7
`define SBC_BIT_CPU_SEL    7
`define SBC_BIT_SUB_SEL    4
`define SBC_BIT_RING_OFF   0
`define SBC_BIT_PERIPH_SEL 0
`define SBC_SELECT_W       3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SBC_RST_STATUS  8'h00
`define SBC_RST_SELECT  3'h5
`define SBC_RST_MOC     1'h1
`define SBC_RST_PCC     1'h1

// ----------------------------------------------------------------
// Timing counts, in main oscillator cycles or ring periods
// ----------------------------------------------------------------
`define SBC_TH11       17'h00800
`define SBC_TH13       17'h02000
`define SBC_TH14       17'h04000
`define SBC_TH15       17'h08000
`define SBC_TH16       17'h10000
`define SBC_RING_HOLD  5'h11

`endif

//--- hw/sbc_pkg.sv
`default_nettype none
package sbc_pkg;

    typedef enum logic [1:0]
    {
        SRC_MAIN = 2'h0,
        SRC_RING = 2'h1,
        SRC_SUB  = 2'h2
    } sbc_src_type;

    typedef enum logic [2:0]
    {
        ST_RUN       = 3'h0,
        ST_HALT      = 3'h1,
        ST_STOP      = 3'h2,
        ST_SETTLE    = 3'h3,
        ST_RING_HOLD = 3'h4
    } sbc_state_type;

endpackage : sbc_pkg
`default_nettype wire

//--- hw/sbc_if.sv
`default_nettype none
interface sbc_if;
    logic [15:0]         addr;
    logic [7:0]          wdata;
    logic                wr;
    logic                rd;
    logic [7:0]          rdata;
    logic                halt_req;
    logic                stop_req;
    logic                irq;
    logic                cpu_clk_en;
    sbc_pkg::sbc_src_type cpu_clk_src;

    modport device
    (
        input  addr, wdata, wr, rd, halt_req, stop_req, irq,
        output rdata, cpu_clk_en, cpu_clk_src
    );

    modport cpu
    (
        output addr, wdata, wr, rd, halt_req, stop_req, irq,
        input  rdata, cpu_clk_en, cpu_clk_src
    );
endinterface : sbc_if
`default_nettype wire

//--- hw/sbc_device.sv
`include "sbc_defs.svh"
`default_nettype none
module sbc_device
#(
    parameter logic [16:0] TH11 = `SBC_TH11,
    parameter logic [16:0] TH13 = `SBC_TH13,
    parameter logic [16:0] TH14 = `SBC_TH14,
    parameter logic [16:0] TH15 = `SBC_TH15,
    parameter logic [16:0] TH16 = `SBC_TH16
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Link to the CPU
    sbc_if.device     bus,
    // Oscillator side
    input  wire logic xtal_tick,
    input  wire logic ring_tick,
    input  wire logic ring_stoppable,
    output logic      main_osc_en,
    output logic      ring_oscillator_en,
    output logic      periph_clk_select,
    output logic [2:0] standby_state
);

    // ----------------------------------------------------------------
    // State and registers
    // ----------------------------------------------------------------
    sbc_pkg::sbc_state_type state_reg;
    sbc_pkg::sbc_state_type state_next;
    sbc_pkg::sbc_src_type   src_reg;
    logic [16:0]            cnt_reg;
    logic                   limit_reg;
    logic [4:0]             ring_cnt_reg;
    logic [2:0]             select_reg;
    logic                   main_off_reg;
    logic                   cpu_sel_reg;
    logic                   sub_sel_reg;
    logic                   ring_off_reg;
    logic                   periph_sel_reg;
    logic                   ring_lock_reg;
    logic                   strap_reg;
    logic                   strap_done_reg;
    logic [7:0]             rdata_reg;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire logic in_run     = (state_reg == sbc_pkg::ST_RUN);
    wire logic wr_ok      = bus.wr && in_run;
    wire logic wr_select  = wr_ok && (bus.addr == `SBC_ADDR_SELECT);
    wire logic wr_moc     = wr_ok && (bus.addr == `SBC_ADDR_MOC);
    wire logic wr_pcc     = wr_ok && (bus.addr == `SBC_ADDR_PCC);
    wire logic wr_rcm     = wr_ok && (bus.addr == `SBC_ADDR_RCM);
    wire logic wr_mcm     = wr_ok && (bus.addr == `SBC_ADDR_MCM);

    wire sbc_pkg::sbc_src_type live_src = sbc_pkg::sbc_src_type'(
        sub_sel_reg ? sbc_pkg::SRC_SUB :
        cpu_sel_reg ? sbc_pkg::SRC_RING : sbc_pkg::SRC_MAIN);

    // Stop from the subsystem clock is not allowed, so it is dropped here too
    wire logic stop_go = in_run && bus.stop_req && (live_src != sbc_pkg::SRC_SUB);
    wire logic halt_go = in_run && bus.halt_req && !bus.stop_req;

    wire logic clr_cnt = stop_go
        || (wr_moc && bus.wdata[`SBC_BIT_MAIN_OFF])
        || (wr_pcc && bus.wdata[`SBC_BIT_CPU_SEL]);

    // Prohibited codes fall back to the longest wait, the safe side
    wire logic [16:0] sel_th =
        (select_reg == 3'h1) ? TH11 :
        (select_reg == 3'h2) ? TH13 :
        (select_reg == 3'h3) ? TH14 :
        (select_reg == 3'h4) ? TH15 : TH16;

    wire logic [16:0] cnt_cap  = limit_reg ? sel_th : TH16;
    // Only real oscillator ticks count, so the start-up gap is excluded
    wire logic cnt_en = xtal_tick && main_osc_en && (cnt_reg < cnt_cap);
    wire logic settled = (cnt_reg >= sel_th);

    wire logic [7:0] status_val =
    {
        3'h0,
        cnt_reg >= TH11,
        cnt_reg >= TH13,
        cnt_reg >= TH14,
        cnt_reg >= TH15,
        cnt_reg >= TH16
    };

    wire logic [7:0] rd_mux =
        (bus.addr == `SBC_ADDR_STATUS) ? status_val :
        (bus.addr == `SBC_ADDR_SELECT) ? {5'h0, select_reg} :
        (bus.addr == `SBC_ADDR_MOC)    ? {main_off_reg, 7'h0} :
        (bus.addr == `SBC_ADDR_PCC)    ? {cpu_sel_reg, 2'h0, sub_sel_reg, 4'h0} :
        (bus.addr == `SBC_ADDR_RCM)    ? {7'h0, ring_off_reg} :
        (bus.addr == `SBC_ADDR_MCM)    ? {7'h0, periph_sel_reg} : 8'h00;

    wire logic ring_done = ring_tick && (ring_cnt_reg == (`SBC_RING_HOLD - 5'h1));

    // ----------------------------------------------------------------
    // Standby sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            sbc_pkg::ST_RUN:
            begin
                if (stop_go)
                    state_next = sbc_pkg::ST_STOP;
                else if (halt_go)
                    state_next = sbc_pkg::ST_HALT;
            end
            sbc_pkg::ST_HALT:
            begin
                if (bus.irq)
                    state_next = sbc_pkg::ST_RUN;
            end
            sbc_pkg::ST_STOP:
            begin
                if (bus.irq && src_reg == sbc_pkg::SRC_RING)
                    state_next = sbc_pkg::ST_RING_HOLD;
                else if (bus.irq)
                    state_next = sbc_pkg::ST_SETTLE;
            end
            sbc_pkg::ST_SETTLE:
            begin
                if (settled)
                    state_next = sbc_pkg::ST_RUN;
            end
            sbc_pkg::ST_RING_HOLD:
            begin
                if (ring_done)
                    state_next = sbc_pkg::ST_RUN;
            end
            default:
                state_next = sbc_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= sbc_pkg::ST_RUN;
            src_reg   <= sbc_pkg::SRC_RING;
        end
        else
        begin
            state_reg <= state_next;
            if (stop_go || halt_go)
                src_reg <= live_src;
        end
    end

    // ----------------------------------------------------------------
    // Settle counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_reg   <= 17'h0;
            limit_reg <= 1'b0;
        end
        else if (clr_cnt)
        begin
            cnt_reg   <= 17'h0;
            limit_reg <= stop_go;
        end
        else if (cnt_en)
            cnt_reg <= cnt_reg + 17'h1;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ring_cnt_reg <= 5'h0;
        else if (state_reg != sbc_pkg::ST_RING_HOLD)
            ring_cnt_reg <= 5'h0;
        else if (ring_tick)
            ring_cnt_reg <= ring_cnt_reg + 5'h1;
    end

    // ----------------------------------------------------------------
    // Clock control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            select_reg     <= `SBC_RST_SELECT;
            main_off_reg   <= `SBC_RST_MOC;
            cpu_sel_reg    <= `SBC_RST_PCC;
            sub_sel_reg    <= 1'b0;
            ring_off_reg   <= 1'b0;
            periph_sel_reg <= 1'b0;
        end
        else
        begin
            if (wr_select)
                select_reg <= bus.wdata[`SBC_SELECT_W-1:0];
            if (wr_moc)
                main_off_reg <= bus.wdata[`SBC_BIT_MAIN_OFF];
            if (wr_pcc)
            begin
                cpu_sel_reg <= bus.wdata[`SBC_BIT_CPU_SEL];
                sub_sel_reg <= bus.wdata[`SBC_BIT_SUB_SEL];
            end
            if (wr_rcm)
                ring_off_reg <= bus.wdata[`SBC_BIT_RING_OFF];
            if (wr_mcm)
                periph_sel_reg <= bus.wdata[`SBC_BIT_PERIPH_SEL];
        end
    end

    // Mask option strap is caught after reset release, never in the reset branch
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strap_reg      <= 1'b0;
            strap_done_reg <= 1'b0;
        end
        else if (!strap_done_reg)
        begin
            strap_reg      <= ring_stoppable;
            strap_done_reg <= 1'b1;
        end
    end

    wire logic ring_stop_req = ring_off_reg && strap_reg && strap_done_reg;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ring_lock_reg <= 1'b0;
        else if (stop_go)
            ring_lock_reg <= !ring_stop_req;
        else if (in_run)
            ring_lock_reg <= 1'b0;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_reg <= 8'h00;
        else if (bus.rd)
            rdata_reg <= rd_mux;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Main crystal halts in stop whatever the CPU clock; ring is untouched
    assign main_osc_en = !main_off_reg && (state_reg != sbc_pkg::ST_STOP);
    assign ring_oscillator_en = ring_lock_reg || !ring_stop_req;
    assign periph_clk_select = periph_sel_reg;
    assign standby_state     = state_reg;
    assign bus.cpu_clk_en    = in_run;
    assign bus.cpu_clk_src   = sbc_pkg::sbc_src_type'(in_run ? live_src : src_reg);
    assign bus.rdata         = rdata_reg;

endmodule : sbc_device
`default_nettype wire

//--- hw/sbc_cpu_end.sv
`include "sbc_defs.svh"
`default_nettype none
module sbc_cpu_end
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Link to the device
    sbc_if.cpu               bus,
    // Register port
    input  wire logic [15:0] sw_addr,
    input  wire logic [7:0]  sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic [7:0]       sw_rdata,
    // Standby commands
    input  wire logic        cmd_halt,
    input  wire logic        cmd_stop,
    input  wire logic        periph_idle,
    input  wire logic        irq_in,
    output logic             conv_stop,
    output logic             cmd_refused,
    output logic             cpu_running
);

    // ----------------------------------------------------------------
    // Pending standby order
    // ----------------------------------------------------------------
    logic pend_halt_reg;
    logic pend_stop_reg;
    logic refused_reg;
    logic conv_reg;

    wire logic on_sub   = (bus.cpu_clk_src == sbc_pkg::SRC_SUB);
    wire logic busy     = pend_halt_reg || pend_stop_reg || !bus.cpu_clk_en;
    wire logic stop_ok  = cmd_stop && !on_sub && periph_idle && !busy;
    wire logic halt_ok  = cmd_halt && !cmd_stop && !busy;
    wire logic refuse   = (cmd_stop && !stop_ok) || (cmd_halt && !cmd_stop && busy);

    // Converter is told to stop in the same cycle as the standby order goes out
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pend_halt_reg <= 1'b0;
            pend_stop_reg <= 1'b0;
            refused_reg   <= 1'b0;
            conv_reg      <= 1'b0;
        end
        else
        begin
            pend_halt_reg <= halt_ok;
            pend_stop_reg <= stop_ok;
            refused_reg   <= refuse;
            conv_reg      <= halt_ok || stop_ok;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign bus.halt_req = pend_halt_reg;
    assign bus.stop_req = pend_stop_reg;
    assign bus.irq      = irq_in;
    // No register writes while the CPU clock is gated; reads pass through
    assign bus.addr     = sw_addr;
    assign bus.wdata    = sw_wdata;
    assign bus.wr       = sw_wr && bus.cpu_clk_en && !busy;
    assign bus.rd       = sw_rd;
    assign sw_rdata     = bus.rdata;
    assign conv_stop    = conv_reg;
    assign cmd_refused  = refused_reg;
    assign cpu_running  = bus.cpu_clk_en;

endmodule : sbc_cpu_end
`default_nettype wire

//--- verif/sbc_link_chk.sv
`include "sbc_defs.svh"
`default_nettype none
module sbc_link_chk
(
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 arst_n,
    // Link signals
    input wire logic [15:0]          addr,
    input wire logic                 rd,
    input wire logic [7:0]           rdata,
    input wire logic                 halt_req,
    input wire logic                 stop_req,
    input wire logic                 irq,
    input wire logic                 cpu_clk_en,
    input wire sbc_pkg::sbc_src_type cpu_clk_src
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    // Remembers which standby mode the clock was gated for
    logic halted_reg;
    wire  is_status = (addr == `SBC_ADDR_STATUS);
    wire  on_sub    = (cpu_clk_src == sbc_pkg::SRC_SUB);

    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
            halted_reg <= 1'b0;
        else if (cpu_clk_en)
            halted_reg <= halt_req & ~stop_req;

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    a_halt_gates_clk: assert property (
        cpu_clk_en && halt_req && !stop_req |=> !cpu_clk_en)
        else $error("halt did not gate cpu clock");
    a_stop_gates_clk: assert property (
        cpu_clk_en && stop_req && !on_sub |=> !cpu_clk_en)
        else $error("stop did not gate cpu clock");
    a_sub_stop_ignored: assert property (
        cpu_clk_en && stop_req && !halt_req && on_sub |=> cpu_clk_en)
        else $error("stop taken on sub clock");
    a_halt_wakes_fast: assert property (
        !cpu_clk_en && halted_reg && irq |=> cpu_clk_en)
        else $error("halt wake was delayed");
    a_stop_waits: assert property (
        !cpu_clk_en && !halted_reg && $rose(irq) |=> !cpu_clk_en [*3])
        else $error("stop wake skipped settle wait");
    a_src_kept: assert property (
        !cpu_clk_en |=> $stable(cpu_clk_src))
        else $error("clock source changed in standby");
    a_status_upper_zero: assert property (
        rd && is_status |=> rdata[7:5] == 3'h0)
        else $error("status upper bits not zero");
    a_status_thermo: assert property (
        rd && is_status |=> rdata[4:0] inside {5'h00, 5'h10, 5'h18, 5'h1C, 5'h1E, 5'h1F})
        else $error("status not a thermometer code");
    a_rdata_holds: assert property (
        !rd |=> $stable(rdata))
        else $error("read data moved without a read");

    c_halt_wake: cover property (!cpu_clk_en && halted_reg && irq);
    c_stop_wake: cover property (!cpu_clk_en && !halted_reg ##1 cpu_clk_en);
    c_status_full: cover property (rd && is_status ##1 rdata == 8'h1F);
endmodule : sbc_link_chk
`default_nettype wire

//--- verif/standby_and_osc_settle_status_tb.sv
`include "sbc_defs.svh"
`default_nettype none
module standby_and_osc_settle_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] sw_addr = '0;
    logic [7:0]  sw_wdata = '0;
    logic [7:0]  sw_rdata;
    logic [7:0]  rv;
    logic        clk = 0, arst_n = 0, sw_wr = 0, sw_rd = 0, irq_in = 0;
    logic        cmd_halt = 0, cmd_stop = 0, periph_idle = 1, ring_tick = 0, strap = 1;
    logic        xtal_tick = 1, periph_sel;
    logic [2:0]  sb_state;
    logic        conv_stop, cmd_refused, cpu_running, main_osc_en, ring_oscillator_en;
    logic        saw_conv, saw_ref;
    int          fail_count = 0, check_count = 0, n, ticks;

    sbc_if link ();
    // Shortened thresholds keep the run brief, order kept
    sbc_device #(.TH11(17'h4), .TH13(17'h8), .TH14(17'h10), .TH15(17'h20), .TH16(17'h40))
    u_sbc_device (.clk(clk), .arst_n(arst_n), .bus(link.device), .xtal_tick(xtal_tick),
        .ring_tick(ring_tick), .ring_stoppable(strap), .main_osc_en(main_osc_en),
        .ring_oscillator_en(ring_oscillator_en), .periph_clk_select(periph_sel), .standby_state(sb_state));
    sbc_cpu_end u_sbc_cpu_end (.clk(clk), .arst_n(arst_n), .bus(link.cpu),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .cmd_halt(cmd_halt), .cmd_stop(cmd_stop),
        .periph_idle(periph_idle), .irq_in(irq_in), .conv_stop(conv_stop),
        .cmd_refused(cmd_refused), .cpu_running(cpu_running));
    sbc_link_chk u_sbc_link_chk (.clk(clk), .arst_n(arst_n), .addr(link.addr), .rd(link.rd),
        .rdata(link.rdata), .halt_req(link.halt_req), .stop_req(link.stop_req),
        .irq(link.irq), .cpu_clk_en(link.cpu_clk_en), .cpu_clk_src(link.cpu_clk_src));

    initial
        forever #25 clk = ~clk;
    always @(posedge clk)
        ring_tick <= ~ring_tick;

    // ------------------------------------------------
    // Shared tasks
    // ------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a);
        @(posedge clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1 rv = sw_rdata;
    endtask : rd
    task automatic cmd(input logic stop);
        @(posedge clk);
        cmd_stop <= stop;
        cmd_halt <= !stop;
        @(posedge clk);
        cmd_stop <= 1'b0;
        cmd_halt <= 1'b0;
        saw_conv = 0;
        saw_ref = 0;
        repeat (3)
        begin
            #1 saw_conv |= conv_stop;
            saw_ref |= cmd_refused;
            @(posedge clk);
        end
    endtask : cmd
    // Counts cycles and ring ticks until the CPU clock returns
    task automatic wake();
        @(posedge clk);
        irq_in <= 1'b1;
        n = 0;
        ticks = 0;
        while (!cpu_running && n < 300)
        begin
            @(posedge clk);
            #1 n++;
            ticks += ring_tick;
        end
        @(posedge clk);
        irq_in <= 1'b0;
    endtask : wake
    task automatic reset_dut(input logic s);
        @(posedge clk);
        arst_n <= 1'b0;
        strap <= s;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : reset_dut
    task automatic ring_mask(input logic exp);
        wr(`SBC_ADDR_MOC, 8'h00);
        wr(`SBC_ADDR_PCC, 8'h00);
        wr(`SBC_ADDR_RCM, 8'h01);
        #1 check({7'h0, ring_oscillator_en}, {7'h0, exp});
        wr(`SBC_ADDR_RCM, 8'h00);
    endtask : ring_mask

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_status();
        rd(`SBC_ADDR_STATUS);
        check(rv, 8'h00);
        rd(`SBC_ADDR_SELECT);
        check(rv, 8'h05);
        rd(16'h0000);
        check(rv, 8'h00);
        wr(`SBC_ADDR_MOC, 8'h00);
        repeat (100) @(posedge clk);
        rd(`SBC_ADDR_STATUS);
        check(rv, 8'h1F);
        wr(`SBC_ADDR_STATUS, 8'hFF);
        rd(`SBC_ADDR_STATUS);
        check(rv, 8'h1F);
        wr(`SBC_ADDR_MOC, 8'h80);
        rd(`SBC_ADDR_STATUS);
        check(rv, 8'h00);
        wr(`SBC_ADDR_MOC, 8'h00);
        repeat (10) @(posedge clk);
        rd(`SBC_ADDR_STATUS);
        check(rv, 8'h18);
        wr(`SBC_ADDR_PCC, 8'h80);
        rd(`SBC_ADDR_STATUS);
        check(rv, 8'h00);
        // Crystal silent: the count must not advance past its few early ticks
        @(posedge clk);
        xtal_tick <= 1'b0;
        repeat (20) @(posedge clk);
        rd(`SBC_ADDR_STATUS);
        check(rv, 8'h00);
        @(posedge clk);
        xtal_tick <= 1'b1;
    endtask : t_status
    task automatic t_halt();
        wr(`SBC_ADDR_SELECT, 8'h02);
        wr(`SBC_ADDR_MCM, 8'h01);
        cmd(1'b0);
        check({5'h0, main_osc_en, ring_oscillator_en, cpu_running}, 8'h06);
        check({5'h0, sb_state}, 8'h01);
        check({7'h0, periph_sel}, 8'h01);
        check({7'h0, saw_conv}, 8'h01);
        wake();
        check({7'h0, n <= 2}, 8'h01);
        rd(`SBC_ADDR_SELECT);
        check(rv, 8'h02);
    endtask : t_halt
    task automatic t_stop_main();
        wr(`SBC_ADDR_PCC, 8'h00);
        cmd(1'b1);
        check({5'h0, main_osc_en, ring_oscillator_en, cpu_running}, 8'h02);
        check({5'h0, sb_state}, 8'h02);
        wake();
        check({7'h0, n >= 8}, 8'h01);
        rd(`SBC_ADDR_STATUS);
        check(rv, 8'h18);
        repeat (70) @(posedge clk);
        rd(`SBC_ADDR_STATUS);
        check(rv, 8'h18);
        check({6'h0, link.cpu_clk_src}, {6'h0, sbc_pkg::SRC_MAIN});
    endtask : t_stop_main
    task automatic t_stop_ring();
        wr(`SBC_ADDR_PCC, 8'h80);
        cmd(1'b1);
        check({5'h0, main_osc_en, ring_oscillator_en, cpu_running}, 8'h02);
        wake();
        check({7'h0, ticks >= 17 && ticks <= 18}, 8'h01);
        check({6'h0, link.cpu_clk_src}, {6'h0, sbc_pkg::SRC_RING});
        // Polled threshold stays within the selected wait
        rd(`SBC_ADDR_STATUS);
        check(rv, 8'h18);
    endtask : t_stop_ring
    task automatic t_refusals();
        wr(`SBC_ADDR_PCC, 8'h10);
        cmd(1'b1);
        check({6'h0, saw_ref, cpu_running}, 8'h03);
        cmd(1'b0);
        check({7'h0, cpu_running}, 8'h00);
        wake();
        check({6'h0, link.cpu_clk_src}, {6'h0, sbc_pkg::SRC_SUB});
        wr(`SBC_ADDR_PCC, 8'h00);
        periph_idle <= 1'b0;
        cmd(1'b1);
        check({6'h0, saw_ref, cpu_running}, 8'h03);
        periph_idle <= 1'b1;
    endtask : t_refusals

    initial
    begin
        repeat (4000) @(posedge clk);
        fail_count++;
        complete_run();
    end

    initial
    begin
        reset_dut(1'b1);
        t_status();
        t_halt();
        t_stop_main();
        t_stop_ring();
        t_refusals();
        ring_mask(1'b0);
        reset_dut(1'b0);
        ring_mask(1'b1);
        complete_run();
    end
endmodule : standby_and_osc_settle_status_tb
`default_nettype wire
